// [dsam_pkg.sv]
// shared constants, types and helpers for the dual sensor alarm monitor
package dsam_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_THR_ONE   = 8'h40;
  localparam logic [7:0] ADDR_THR_TWO   = 8'h42;
  localparam logic [7:0] ADDR_CNT_ONE   = 8'h44;
  localparam logic [7:0] ADDR_CNT_TWO   = 8'h46;
  localparam logic [7:0] ADDR_CTRL      = 8'h48;
  localparam logic [7:0] ADDR_DIAG      = 8'h4A;
  localparam logic [7:0] ADDR_INT_STAT  = 8'h4C;
  localparam logic [7:0] ADDR_INT_MASK  = 8'h4E;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_SEL_TWO_LSB = 12;
  localparam int unsigned CTRL_SEL_ONE_LSB = 8;
  localparam int unsigned CTRL_DYN_TWO     = 7;
  localparam int unsigned CTRL_DYN_ONE     = 6;
  localparam int unsigned CTRL_POL_TWO     = 5;
  localparam int unsigned CTRL_POL_ONE     = 4;
  localparam int unsigned CTRL_FILT        = 3;
  localparam int unsigned CTRL_IND_EN      = 2;
  localparam int unsigned CTRL_IND_POL     = 1;
  localparam int unsigned CTRL_IND_SEL     = 0;
  localparam int unsigned CNT_LSB          = 0;
  localparam int unsigned DIAG_ALM_LSB     = 8;
  localparam int unsigned DIAG_PIN_LSB     = 0;
  localparam logic [15:0] REG_RST_VAL      = 16'h0000;

  // ----------------------------------------------------------------
  // source codes and timing
  // ----------------------------------------------------------------
  localparam logic [3:0]  SEL_DISABLE  = 4'h0;
  localparam logic [3:0]  SEL_HOLE     = 4'h8;
  localparam logic [3:0]  SEL_LAST     = 4'hC;
  localparam int unsigned SAMPLE_RATE_MILLI_SPS = 819200;
  localparam int unsigned HIST_DEPTH   = 256;

  typedef logic [15:0]       dsam_word_t;
  typedef logic [15:0][15:0] dsam_bank_t;

  // a code names a real output register
  function automatic logic dsam_sel_ok(input logic [3:0] s);
    return (s != SEL_DISABLE) && (s != SEL_HOLE) && (s <= SEL_LAST);
  endfunction

endpackage

// [dsam_chan_if.sv]
// per-channel settings, sample feed and result between top and channel
`timescale 1ns/1ps
interface dsam_chan_if;
  logic [3:0]  sel;
  logic        dyn;
  logic        pol_gt;
  logic [7:0]  nsamp;
  logic [15:0] thr;
  logic [15:0] value;
  logic        stb;
  logic        alarm;

  modport ctl  (output sel, dyn, pol_gt, nsamp, thr, value, stb, input alarm);
  modport chan (input sel, dyn, pol_gt, nsamp, thr, value, stb, output alarm);
endinterface

// [dsam_chan.sv]
// one alarm channel: static or rate-of-change compare with sample history
`timescale 1ns/1ps
module dsam_chan #(
  parameter int DEPTH = 256
) (
  input wire logic   clk_i,
  input wire logic   rst_n_i,
  dsam_chan_if.chan  cif
);
  import dsam_pkg::*;

  localparam int PW = $clog2(DEPTH);

  logic [15:0]   hist [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [7:0]    fill_r;
  logic          alarm_r;
  logic [7:0]    n_eff;
  logic [15:0]   old_v;
  logic signed [16:0] diff;
  logic [16:0]   mag;
  logic          hit_st;
  logic          hit_dyn;
  logic          sel_ok;
  logic          alarm_nxt;

  // ----------------------------------------------------------------
  // compare
  // ----------------------------------------------------------------
  assign sel_ok  = dsam_sel_ok(cif.sel);
  assign n_eff   = (cif.nsamp < 8'h02) ? 8'h01 : cif.nsamp;
  assign old_v   = hist[wr_ptr_r - PW'(n_eff)];
  assign diff    = $signed({cif.value[15], cif.value}) - $signed({old_v[15], old_v});
  assign mag     = diff[16] ? 17'(-diff) : 17'(diff);
  // threshold shares the source format, so a plain signed compare works
  assign hit_st  = cif.pol_gt ? ($signed(cif.value) > $signed(cif.thr))
                              : ($signed(cif.value) < $signed(cif.thr));
  assign hit_dyn = (fill_r >= n_eff) && (cif.pol_gt ? (mag > {1'b0, cif.thr})
                                                    : (mag < {1'b0, cif.thr}));
  assign alarm_nxt = sel_ok && (cif.dyn ? hit_dyn : hit_st);
  assign cif.alarm = alarm_r;

  // ----------------------------------------------------------------
  // history, one entry per sample update
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (cif.stb) begin
      hist[wr_ptr_r] <= cif.value;
    end
  end

  // history restarts when the channel is off; a source change while on keeps stale entries
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !sel_ok) begin
      wr_ptr_r <= '0;
      fill_r   <= 8'h00;
    end else if (cif.stb) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
      if (fill_r != 8'hFF) begin
        fill_r <= fill_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !sel_ok) begin
      alarm_r <= 1'b0;
    end else if (cif.stb) begin
      alarm_r <= alarm_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_static_cmp;
    @(posedge clk_i) disable iff (!rst_n_i)
      cif.stb && sel_ok && !cif.dyn && dsam_sel_ok(cif.sel) |=>
        (alarm_r == $past(hit_st)) || !$past(sel_ok);
  endproperty
  a_static_cmp: assert property (p_static_cmp) else $error("static alarm mismatch");

  property p_dyn_cmp;
    @(posedge clk_i) disable iff (!rst_n_i)
      cif.stb && sel_ok && cif.dyn |=> alarm_r == $past(hit_dyn);
  endproperty
  a_dyn_cmp: assert property (p_dyn_cmp) else $error("dynamic alarm mismatch");

  property p_disabled;
    @(posedge clk_i) disable iff (!rst_n_i)
      !sel_ok |=> !alarm_r;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled channel alarmed");

  property p_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      !cif.stb && sel_ok && $past(sel_ok) |=> $stable(alarm_r);
  endproperty
  a_hold: assert property (p_hold) else $error("alarm moved without sample");

endmodule

// [dsam_irq.sv]
// sticky event status, read-to-clear, with mask and one level interrupt
`timescale 1ns/1ps
module dsam_irq #(
  parameter int N = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [N-1:0] evt_i,
  input  wire logic         mask_wr_i,
  input  wire logic [N-1:0] mask_wdata_i,
  input  wire logic         stat_rd_i,
  output logic      [N-1:0] stat_o,
  output logic      [N-1:0] mask_o,
  output logic              irq_o
);
  import dsam_pkg::*;

  logic [N-1:0] stat_r;
  logic [N-1:0] mask_r;

  // a new event in the read cycle survives the clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      stat_r <= '0;
    end else begin
      stat_r <= (stat_rd_i ? '0 : stat_r) | evt_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mask_r <= '0;
    end else if (mask_wr_i) begin
      mask_r <= mask_wdata_i;
    end
  end

  assign stat_o = stat_r;
  assign mask_o = mask_r;
  assign irq_o  = |(stat_r & mask_r);

endmodule

// [dsam_top.sv]
// dual sensor alarm monitor: registers, source muxing, channels, indicator pins
//
// Contract
// - two independent channels, each with own threshold, polarity and source.
// - static mode compares selected source value with channel threshold each update.
// - threshold uses the same numeric format as the selected source.
// - dynamic mode compares change over programmed samples with threshold magnitude.
// - sample count is low byte; zero and one both mean one sample.
// - diagnostic status bits nine and eight show channel two and one alarms.
// - control top nibble selects channel two source, next nibble channel one.
// - codes: 0 off, 1-3 gyro, 4-6 accel, 7/9/10 magnet, 11 pressure, 12 temp.
// - control bits 7 and 6 select dynamic mode for channels two and one.
// - control bits 5 and 4: one triggers above threshold, zero below.
// - control bit 3 picks filtered or unfiltered source data.
// - control bit 2 enables driving the indicator onto a pin.
// - control bit 1 sets indicator active level, high when one.
// - control bit 0 routes indicator to pin two when one, else pin one.
// - thresholds, counts and control reset to zero; channels off, indicator off.
// - dynamic period is sample count over sample rate, one count per update.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module dsam_top #(
  parameter int HIST_DEPTH_P = dsam_pkg::HIST_DEPTH
) (
  input  wire logic                MCLK_I,
  input  wire logic                RESETN_I,
  input  wire logic [7:0]          ADDR_I,
  input  wire logic [15:0]         WDATA_I,
  input  wire logic                WR_I,
  input  wire logic                RD_I,
  output logic      [15:0]         RDATA_O,
  input  wire logic                SAMPLE_STB_I,
  input  wire dsam_pkg::dsam_bank_t SENS_RAW_I,
  input  wire dsam_pkg::dsam_bank_t SENS_FILT_I,
  output logic      [1:0]          DIAG_ALARM_O,
  input  wire logic                GP_IO_ONE_I,
  output logic                     GP_IO_ONE_O,
  output logic                     GP_IO_ONE_OE_O,
  input  wire logic                GP_IO_TWO_I,
  output logic                     GP_IO_TWO_O,
  output logic                     GP_IO_TWO_OE_O,
  output logic                     IRQ_O
);
  import dsam_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [15:0] thr_one_r;
  logic [15:0] thr_two_r;
  logic [7:0]  cnt_one_r;
  logic [7:0]  cnt_two_r;
  logic [15:0] ctrl_r;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic [1:0]  alarm;
  logic [1:0]  alarm_d_r;
  logic [1:0]  evt;
  logic [1:0]  int_stat;
  logic [1:0]  int_mask;
  logic        wr_mask;
  logic        rd_stat;
  logic [2:0]  pin_one_sync_r;
  logic [2:0]  pin_two_sync_r;
  logic [1:0]  pin_lvl_r;
  logic        ind_level;
  logic        pin_one_r;
  logic        pin_two_r;
  logic        oe_one_r;
  logic        oe_two_r;

  dsam_chan_if ch_one ();
  dsam_chan_if ch_two ();

  // pick a source word, raw or filtered
  function automatic logic [15:0] pick_src(input logic [3:0] sel, input logic filt,
                                           input dsam_bank_t raw, input dsam_bank_t flt);
    return filt ? flt[sel] : raw[sel];
  endfunction

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      thr_one_r <= REG_RST_VAL;
      thr_two_r <= REG_RST_VAL;
    end else if (WR_I) begin
      if (ADDR_I == ADDR_THR_ONE) begin
        thr_one_r <= WDATA_I;
      end
      if (ADDR_I == ADDR_THR_TWO) begin
        thr_two_r <= WDATA_I;
      end
    end
  end

  // only the low byte is stored; upper byte reads zero
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      cnt_one_r <= REG_RST_VAL[7:0];
      cnt_two_r <= REG_RST_VAL[7:0];
    end else if (WR_I) begin
      if (ADDR_I == ADDR_CNT_ONE) begin
        cnt_one_r <= WDATA_I[CNT_LSB +: 8];
      end
      if (ADDR_I == ADDR_CNT_TWO) begin
        cnt_two_r <= WDATA_I[CNT_LSB +: 8];
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      ctrl_r <= REG_RST_VAL;
    end else if (WR_I && (ADDR_I == ADDR_CTRL)) begin
      ctrl_r <= WDATA_I;
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = 16'h0000;
    unique case (ADDR_I)
      ADDR_THR_ONE:  rdata_nxt = thr_one_r;
      ADDR_THR_TWO:  rdata_nxt = thr_two_r;
      ADDR_CNT_ONE:  rdata_nxt = {8'h00, cnt_one_r};
      ADDR_CNT_TWO:  rdata_nxt = {8'h00, cnt_two_r};
      ADDR_CTRL:     rdata_nxt = ctrl_r;
      ADDR_DIAG: begin
        rdata_nxt[DIAG_ALM_LSB +: 2] = alarm;
        rdata_nxt[DIAG_PIN_LSB +: 2] = pin_lvl_r;
      end
      ADDR_INT_STAT: rdata_nxt = {14'h0000, int_stat};
      ADDR_INT_MASK: rdata_nxt = {14'h0000, int_mask};
      default:       rdata_nxt = 16'h0000;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      rdata_r <= 16'h0000;
    end else if (RD_I) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign RDATA_O = rdata_r;

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  assign ch_one.sel    = ctrl_r[CTRL_SEL_ONE_LSB +: 4];
  assign ch_two.sel    = ctrl_r[CTRL_SEL_TWO_LSB +: 4];
  assign ch_one.dyn    = ctrl_r[CTRL_DYN_ONE];
  assign ch_two.dyn    = ctrl_r[CTRL_DYN_TWO];
  assign ch_one.pol_gt = ctrl_r[CTRL_POL_ONE];
  assign ch_two.pol_gt = ctrl_r[CTRL_POL_TWO];
  assign ch_one.nsamp  = cnt_one_r;
  assign ch_two.nsamp  = cnt_two_r;
  assign ch_one.thr    = thr_one_r;
  assign ch_two.thr    = thr_two_r;
  assign ch_one.stb    = SAMPLE_STB_I;
  assign ch_two.stb    = SAMPLE_STB_I;
  assign ch_one.value  = pick_src(ch_one.sel, ctrl_r[CTRL_FILT], SENS_RAW_I, SENS_FILT_I);
  assign ch_two.value  = pick_src(ch_two.sel, ctrl_r[CTRL_FILT], SENS_RAW_I, SENS_FILT_I);

  // two separate instances share only clock, reset, the sample strobe, the filter select bit and the raw and filtered sensor banks
  dsam_chan #(.DEPTH(HIST_DEPTH_P)) u_chan_one (
    .clk_i   (MCLK_I),
    .rst_n_i (RESETN_I),
    .cif     (ch_one)
  );

  dsam_chan #(.DEPTH(HIST_DEPTH_P)) u_chan_two (
    .clk_i   (MCLK_I),
    .rst_n_i (RESETN_I),
    .cif     (ch_two)
  );

  assign alarm        = {ch_two.alarm, ch_one.alarm};
  assign DIAG_ALARM_O = alarm;

  // ----------------------------------------------------------------
  // interrupts: alarm onset is the event
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      alarm_d_r <= 2'h0;
    end else begin
      alarm_d_r <= alarm;
    end
  end

  assign evt     = alarm & ~alarm_d_r;
  assign wr_mask = WR_I && (ADDR_I == ADDR_INT_MASK);
  assign rd_stat = RD_I && (ADDR_I == ADDR_INT_STAT);

  dsam_irq #(.N(2)) u_irq (
    .clk_i        (MCLK_I),
    .rst_n_i      (RESETN_I),
    .evt_i        (evt),
    .mask_wr_i    (wr_mask),
    .mask_wdata_i (WDATA_I[1:0]),
    .stat_rd_i    (rd_stat),
    .stat_o       (int_stat),
    .mask_o       (int_mask),
    .irq_o        (IRQ_O)
  );

  // ----------------------------------------------------------------
  // pin level readback through three flops
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      pin_one_sync_r <= 3'h0;
      pin_two_sync_r <= 3'h0;
    end else begin
      pin_one_sync_r <= {pin_one_sync_r[1:0], GP_IO_ONE_I};
      pin_two_sync_r <= {pin_two_sync_r[1:0], GP_IO_TWO_I};
    end
  end

  // a level counts only once the last two stages agree
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      pin_lvl_r <= 2'h0;
    end else begin
      if (pin_one_sync_r[2] == pin_one_sync_r[1]) begin
        pin_lvl_r[0] <= pin_one_sync_r[2];
      end
      if (pin_two_sync_r[2] == pin_two_sync_r[1]) begin
        pin_lvl_r[1] <= pin_two_sync_r[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // hardware indicator
  // ----------------------------------------------------------------
  // either alarm lights the indicator; level follows the polarity bit
  assign ind_level = (|alarm) ? ctrl_r[CTRL_IND_POL] : ~ctrl_r[CTRL_IND_POL];

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      oe_one_r <= 1'b0;
      oe_two_r <= 1'b0;
    end else begin
      oe_one_r <= ctrl_r[CTRL_IND_EN] && !ctrl_r[CTRL_IND_SEL];
      oe_two_r <= ctrl_r[CTRL_IND_EN] && ctrl_r[CTRL_IND_SEL];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      pin_one_r <= 1'b0;
      pin_two_r <= 1'b0;
    end else begin
      pin_one_r <= (ctrl_r[CTRL_IND_EN] && !ctrl_r[CTRL_IND_SEL]) ? ind_level : 1'b0;
      pin_two_r <= (ctrl_r[CTRL_IND_EN] && ctrl_r[CTRL_IND_SEL]) ? ind_level : 1'b0;
    end
  end

  assign GP_IO_ONE_O    = pin_one_r;
  assign GP_IO_TWO_O    = pin_two_r;
  assign GP_IO_ONE_OE_O = oe_one_r;
  assign GP_IO_TWO_OE_O = oe_two_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_reset_zero;
    @(posedge MCLK_I) !RESETN_I |=> (ctrl_r == 16'h0000) && (thr_one_r == 16'h0000)
                                  && (cnt_two_r == 8'h00) && !GP_IO_ONE_OE_O;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("registers not reset");

  property p_diag_read;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      RD_I && (ADDR_I == ADDR_DIAG) |=> RDATA_O[9:8] == $past(alarm);
  endproperty
  a_diag_read: assert property (p_diag_read) else $error("diag alarm bits wrong");

  property p_sel_write;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      WR_I && (ADDR_I == ADDR_CTRL) |=>
        (ch_two.sel == $past(WDATA_I[15:12])) && (ch_one.sel == $past(WDATA_I[11:8]));
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("source select not stored");

  property p_cnt_upper;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      RD_I && ((ADDR_I == ADDR_CNT_ONE) || (ADDR_I == ADDR_CNT_TWO)) |=> RDATA_O[15:8] == 8'h00;
  endproperty
  a_cnt_upper: assert property (p_cnt_upper) else $error("count upper byte not zero");

  property p_ind_off;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      !ctrl_r[CTRL_IND_EN] ##1 !$past(ctrl_r[CTRL_IND_EN]) |-> !GP_IO_ONE_OE_O && !GP_IO_TWO_OE_O;
  endproperty
  a_ind_off: assert property (p_ind_off) else $error("indicator driven while off");

  property p_ind_route;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      ctrl_r[CTRL_IND_EN] |=> (GP_IO_TWO_OE_O == $past(ctrl_r[CTRL_IND_SEL]))
                           && (GP_IO_ONE_OE_O == !$past(ctrl_r[CTRL_IND_SEL]));
  endproperty
  a_ind_route: assert property (p_ind_route) else $error("indicator on wrong pin");

  property p_ind_level;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      ctrl_r[CTRL_IND_EN] && ctrl_r[CTRL_IND_SEL] |=>
        GP_IO_TWO_O == ($past(|alarm) ~^ $past(ctrl_r[CTRL_IND_POL]));
  endproperty
  a_ind_level: assert property (p_ind_level) else $error("indicator level wrong");

  property p_filt_src;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      ctrl_r[CTRL_FILT] |-> ch_one.value == SENS_FILT_I[ch_one.sel];
  endproperty
  a_filt_src: assert property (p_filt_src) else $error("filtered source not used");

  property p_read_once;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      !RD_I |=> RDATA_O == 16'h0000;
  endproperty
  a_read_once: assert property (p_read_once) else $error("read data held too long");

  property p_irq_level;
    @(posedge MCLK_I) disable iff (!RESETN_I)
      $rose(ch_one.alarm) && int_mask[0] |=> IRQ_O;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt missed alarm onset");

endmodule

// [dsam_host_pins.sv]
// host-side model of the two general-purpose pins, with pull-ups
`timescale 1ns/1ps
module dsam_host_pins (
  input  wire logic drv_one_i,
  input  wire logic oe_one_i,
  input  wire logic drv_two_i,
  input  wire logic oe_two_i,
  output logic      pin_one_o,
  output logic      pin_two_o
);
  // released pin floats to the pull-up level, never the last driven value
  assign pin_one_o = oe_one_i ? drv_one_i : 1'b1;
  assign pin_two_o = oe_two_i ? drv_two_i : 1'b1;
endmodule

// [tb.sv]
// self-checking bench for the dual sensor alarm monitor
`timescale 1ns/1ps
module tb;
  import dsam_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [15:0] rdata;
  logic       stb = 1'b0;
  dsam_bank_t raw = '0;
  dsam_bank_t filt = '0;
  logic [1:0] alarm;
  logic       p1_o, p1_oe, p2_o, p2_oe, p1, p2, irq;
  int         err_total = 0;
  int         n_compared = 0;
  int         i;

  dsam_top #(.HIST_DEPTH_P(16)) i_dsam_top (.MCLK_I(clk), .RESETN_I(rst_n),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .SAMPLE_STB_I(stb), .SENS_RAW_I(raw), .SENS_FILT_I(filt), .DIAG_ALARM_O(alarm),
    .GP_IO_ONE_I(p1), .GP_IO_ONE_O(p1_o), .GP_IO_ONE_OE_O(p1_oe),
    .GP_IO_TWO_I(p2), .GP_IO_TWO_O(p2_o), .GP_IO_TWO_OE_O(p2_oe), .IRQ_O(irq));
  dsam_host_pins i_dsam_host_pins (.drv_one_i(p1_o), .oe_one_i(p1_oe),
    .drv_two_i(p2_o), .oe_two_i(p2_oe), .pin_one_o(p1), .pin_two_o(p2));

  initial begin
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), exp, rdata);
  endtask
  // one update, then wait for alarm, pin and interrupt to settle
  task automatic sample();
    @(posedge clk);
    stb <= 1'b1;
    @(posedge clk);
    stb <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    $display("compares %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog against a hung sequence
  initial begin
    #400000;
    err_total++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 5; i++) rd_chk(ADDR_THR_ONE + 8'(2 * i), 16'h0000);
    chk("alarms", 16'h0000, {14'h0000, alarm});
    chk("oe", 16'h0000, {14'h0000, p1_oe, p2_oe});
    wr_reg(ADDR_CNT_ONE, 16'hABCD);
    rd_chk(ADDR_CNT_ONE, 16'h00CD);
    rd_chk(8'h50, 16'h0000);
    wr_reg(ADDR_INT_MASK, 16'h0003);
    // static channel one on accel z, trigger below threshold
    wr_reg(ADDR_THR_ONE, 16'h0348);
    rd_chk(ADDR_THR_ONE, 16'h0348);
    @(posedge clk);
    raw[6] <= 16'h0300;
    filt[6] <= 16'h0400;
    wr_reg(ADDR_CTRL, 16'h0600);
    rd_chk(ADDR_CTRL, 16'h0600);
    sample();
    chk("alarm one low", 16'h0001, {14'h0000, alarm});
    rd_chk(ADDR_DIAG, 16'h0103);
    @(posedge clk);
    raw[6] <= 16'h0348;
    sample();
    chk("alarm at equal", 16'h0000, {14'h0000, alarm});
    @(posedge clk);
    raw[6] <= 16'h8000;
    sample();
    chk("alarm signed", 16'h0001, {14'h0000, alarm});
    @(posedge clk);
    raw[6] <= 16'h0300;
    wr_reg(ADDR_CTRL, 16'h0608);
    sample();
    chk("alarm filtered", 16'h0000, {14'h0000, alarm});
    wr_reg(ADDR_CTRL, 16'h0618);
    sample();
    chk("alarm above", 16'h0001, {14'h0000, alarm});
    chk("pin off", 16'h0000, {14'h0000, p1_oe, p2_oe});
    wr_reg(ADDR_CTRL, 16'h061F);
    sample();
    chk("pin two", 16'h0003, {14'h0000, p2_oe, p2_o});
    chk("pin one idle", 16'h0000, {15'h0000, p1_oe});
    wr_reg(ADDR_CTRL, 16'h061C);
    sample();
    chk("pin one low", 16'h0002, {14'h0000, p1_oe, p1_o});
    rd_chk(ADDR_DIAG, 16'h0102);
    // channel one off by a hole code, channel two dynamic on gyro z
    wr_reg(ADDR_THR_TWO, 16'h0010);
    wr_reg(ADDR_CNT_TWO, 16'hFF02);
    rd_chk(ADDR_CNT_TWO, 16'h0002);
    @(posedge clk);
    raw[3] <= 16'h0000;
    wr_reg(ADDR_CTRL, 16'h38A0);
    sample();
    chk("hole code", 16'h0000, {14'h0000, alarm});
    rd_chk(ADDR_INT_STAT, 16'h0001);
    chk("irq clear", 16'h0000, {15'h0000, irq});
    sample();
    sample();
    @(posedge clk);
    raw[3] <= 16'h0011;
    sample();
    chk("dyn rise", 16'h0002, {14'h0000, alarm});
    chk("irq set", 16'h0001, {15'h0000, irq});
    sample();
    chk("dyn hold", 16'h0002, {14'h0000, alarm});
    sample();
    chk("dyn span", 16'h0000, {14'h0000, alarm});
    rd_chk(ADDR_INT_STAT, 16'h0002);
    chk("irq read", 16'h0000, {15'h0000, irq});
    // channel one dynamic, trigger below, count zero means one sample
    wr_reg(ADDR_CNT_ONE, 16'h0000);
    wr_reg(ADDR_CTRL, 16'h36E0);
    sample();
    chk("dyn one fill", 16'h0000, {14'h0000, alarm});
    sample();
    chk("dyn one below", 16'h0001, {14'h0000, alarm});
    chk("irq one", 16'h0001, {15'h0000, irq});
    end_sim();
  end
endmodule
